/* tb/ticc_pin_model.sv */
// Far-side model: capture pins, changed off the bus clock edges, and external counter clock in 37/41 ns steps
`timescale 1ns/1ps
module ticc_pin_model (
   // Pins toward the timer
   output logic [ticc_pkg::NUM_CHAN-1:0] pin_out,
   output logic ext_clk_out
);
   // Pins rest low; the external clock stands still outside bursts
   initial begin
      pin_out = '0;
      ext_clk_out = 1'b0;
   end
   // Odd delay keeps pin changes away from the bus clock edge, so the synchroniser sees a true async input
   task automatic set_pin(input int ch, input logic lvl);
      #3 pin_out[ch] = lvl;
   endtask
   // Slow pulses so each one survives the two-flop synchroniser
   task automatic ext_pulses(input int n);
      repeat (n) begin
         #37 ext_clk_out = 1'b1;
         #41 ext_clk_out = 1'b0;
      end
   endtask
endmodule

/* tb/timer_input_capture_channels_tb_top.sv */
// Self-checking bench of the capture timer over AHB-Lite
`timescale 1ns/1ps
module timer_input_capture_channels_tb_top;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, c1, c2, d0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = ticc_pkg::HSIZE_WORD;
   logic hreadyout, hresp, irq;
   logic [ticc_pkg::NUM_CHAN-1:0] pins;
   logic ext_clk;
   int n_mismatch = 0, checked = 0, ch, mode;
   logic lvl [6];
   logic [7:0] v1, v2;
   logic [15:0] cap, cap_prev, dd, dd0;

   // Bus clock, 100 MHz
   always #5 clk_sys_in = ~clk_sys_in;

   ticc_capture_timer u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
      .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp), .chan_pin_in(pins),
      .ext_timer_clock_pin_in(ext_clk), .irq_out(irq));
   ticc_pin_model u_pins (.pin_out(pins), .ext_clk_out(ext_clk));

   // Verdict in one place
   task automatic results();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait for hready; a hung bus ends the run
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
         results();
      end
   endtask
   // One single AHB-Lite word transfer; read data taken at the edge ending the data phase
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= ticc_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_rdy();
      r = hrdata;
      // Slave must answer OKAY on every transfer
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] x;
      bus(idx, 1'b1, d, x);
   endtask
   function automatic logic [7:0] ctrl_idx(input int c);
      return ticc_pkg::IDX_CHAN0_CTRL + 8'(3 * c);
   endfunction
   // Readable control bits: flag never set by a write, bit 5 absent on odd channels
   function automatic logic [7:0] exp_ctrl(input int c, input logic [7:0] d);
      return d & ((c % 2) ? 8'h5f : 8'h7f);
   endfunction
   // Toggle a pin and let synchroniser, capture and registered interrupt settle
   task automatic toggle(input int c);
      lvl[c] = ~lvl[c];
      u_pins.set_pin(c, lvl[c]);
      repeat (8) @(posedge clk_sys_in);
   endtask
   task automatic read_cap(input int c, output logic [15:0] v);
      bus(ctrl_idx(c) + 8'h01, 1'b0, 8'h00, rd);
      v[15:8] = rd[7:0];
      bus(ctrl_idx(c) + 8'h02, 1'b0, 8'h00, rd);
      v[7:0] = rd[7:0];
   endtask

   initial begin
      foreach (lvl[i]) lvl[i] = 1'b0;
      void'($urandom(49));
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      // Control resets and field layout per channel
      for (int c = 3; c < 6; c++) begin
         bus(ctrl_idx(c), 1'b0, 8'h00, rd);
         chk(rd, 32'h0);
         wr(ctrl_idx(c), 8'hff);
         bus(ctrl_idx(c), 1'b0, 8'h00, rd);
         chk(rd, {24'h0, exp_ctrl(c, 8'hff)});
         wr(ctrl_idx(c), 8'h00);
      end
      bus(8'h00, 1'b0, 8'h00, rd);
      chk(rd, 32'h0);
      // Random value bytes land in high and low halves
      for (int c = 2; c < 6; c++) begin
         v1 = 8'($urandom);
         v2 = 8'($urandom);
         wr(ctrl_idx(c) + 8'h01, v1);
         wr(ctrl_idx(c) + 8'h02, v2);
         read_cap(c, cap);
         chk(cap, {v1, v2});
      end
      // Rising capture on channel 3 lies between two counter reads
      wr(ctrl_idx(3), 8'h44);
      bus(ticc_pkg::IDX_COUNTER, 1'b0, 8'h00, c1);
      toggle(3);
      bus(ticc_pkg::IDX_COUNTER, 1'b0, 8'h00, c2);
      read_cap(3, cap);
      chk(cap > c1[15:0] && cap < c2[15:0], 1);
      bus(ctrl_idx(3), 1'b0, 8'h00, rd);
      chk(rd[7], 1'b1);
      chk(irq, 1'b1);
      // Second rising edge with flag still set overwrites
      cap_prev = cap;
      toggle(3);
      toggle(3);
      read_cap(3, cap);
      chk(cap > cap_prev, 1);
      // Writing one to the flag keeps it, writing zero clears it
      wr(ctrl_idx(3), 8'hc4);
      bus(ctrl_idx(3), 1'b0, 8'h00, rd);
      chk(rd[7:0], 8'hc4);
      wr(ctrl_idx(3), 8'h44);
      bus(ctrl_idx(3), 1'b0, 8'h00, rd);
      chk(rd[7:0], 8'h44);
      repeat (2) @(posedge clk_sys_in);
      chk(irq, 1'b0);
      wr(ctrl_idx(3), 8'h00);
      // Random channels and edge modes: flag follows the selected direction
      for (int k = 0; k < 8; k++) begin
         ch = 3 + int'($urandom % 3);
         mode = 1 + int'($urandom % 3);
         wr(ctrl_idx(ch), 8'(mode << 2));
         toggle(ch);
         bus(ctrl_idx(ch), 1'b0, 8'h00, rd);
         chk(rd[7], lvl[ch] ? mode[0] : mode[1]);
         wr(ctrl_idx(ch), 8'h00);
      end
      // Output mode ignores pin edges
      wr(ctrl_idx(4), 8'h1c);
      toggle(4);
      bus(ctrl_idx(4), 1'b0, 8'h00, rd);
      chk(rd[7:0], 8'h1c);
      wr(ctrl_idx(4), 8'h00);
      // Sticky event status with mask drives the interrupt; earlier captures are cleared first
      wr(ticc_pkg::IDX_EVENT_STATUS, 8'h3f);
      wr(ctrl_idx(5), 8'h0c);
      toggle(5);
      chk(irq, 1'b0);
      bus(ticc_pkg::IDX_EVENT_STATUS, 1'b0, 8'h00, rd);
      chk(rd[5:0], 6'h20);
      wr(ticc_pkg::IDX_EVENT_MASK, 8'h20);
      repeat (2) @(posedge clk_sys_in);
      chk(irq, 1'b1);
      wr(ticc_pkg::IDX_EVENT_STATUS, 8'h20);
      repeat (2) @(posedge clk_sys_in);
      chk(irq, 1'b0);
      // Prescale codes 0..6 slow the shared counter by powers of two
      for (int k = 0; k < 7; k++) begin
         wr(ticc_pkg::IDX_TIMER_CONFIG, 8'(k));
         bus(ticc_pkg::IDX_COUNTER, 1'b0, 8'h00, c1);
         repeat (256) @(posedge clk_sys_in);
         bus(ticc_pkg::IDX_COUNTER, 1'b0, 8'h00, c2);
         // Differences taken modulo the 16-bit counter so a wrap in between does no harm
         dd = c2[15:0] - c1[15:0];
         if (k == 0) dd0 = dd;
         chk(32'(dd) + 1 >= 32'(dd0 >> k) && 32'(dd) <= 32'(dd0 >> k) + 1, 1);
      end
      // External clock code counts pin pulses exactly
      wr(ticc_pkg::IDX_TIMER_CONFIG, 8'h07);
      bus(ticc_pkg::IDX_COUNTER, 1'b0, 8'h00, c1);
      u_pins.ext_pulses(10);
      repeat (6) @(posedge clk_sys_in);
      bus(ticc_pkg::IDX_COUNTER, 1'b0, 8'h00, c2);
      chk({16'h0, 16'(c2[15:0] - c1[15:0])}, 32'd10);
      // Reset keeps captured values
      wr(ticc_pkg::IDX_CHAN2_VALUE_HIGH, 8'h5a);
      wr(ticc_pkg::IDX_CHAN2_VALUE_LOW, 8'hc3);
      rst_in <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      read_cap(2, cap);
      chk(cap, 16'h5ac3);
      results();
   end
endmodule

/* verilog/ticc_capture_timer.sv */
// Timer slice: prescaler, shared counter, six capture channels, AHB-Lite registers
`timescale 1ns/1ps

module ticc_capture_timer (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Pins
   input wire logic [ticc_pkg::NUM_CHAN-1:0] chan_pin_in,
   input wire logic ext_timer_clock_pin_in,
   // Interrupt
   output logic irq_out
);

   // Bus data phase state
   logic wr_pend_q;                          // Write waiting for its data phase
   logic [ticc_pkg::IDX_W-1:0] addr_q;       // Index latched in address phase

   // Timer state
   logic [ticc_pkg::DIV_W-1:0] div_q;        // Free divider feeding the prescaler
   logic [2:0] prescale_select_q;            // Counter rate select
   logic [ticc_pkg::CNT_W-1:0] cnt_q;        // Shared free-running counter
   logic [2:0] ext_sync_q;                   // External clock sync and edge history

   // Channel state
   ticc_pkg::ticc_chan_ctrl_t ctrl_q [ticc_pkg::NUM_CHAN];
   logic [ticc_pkg::CNT_W-1:0] val_q [ticc_pkg::NUM_CHAN];
   logic [ticc_pkg::NUM_CHAN-1:0] pin_s1_q;  // First sync stage, read only by the second
   logic [ticc_pkg::NUM_CHAN-1:0] pin_s2_q;  // Synchronised pin level
   logic [ticc_pkg::NUM_CHAN-1:0] pin_s3_q;  // Previous synchronised level

   // Interrupt status and mask
   logic [ticc_pkg::NUM_CHAN-1:0] evt_stat_q;
   logic [ticc_pkg::NUM_CHAN-1:0] evt_mask_q;

   // Decode of the address phase
   wire addr_take = hsel_in & htrans_in[1] & hready_in;
   wire [ticc_pkg::IDX_W-1:0] addr_idx = haddr_in[9:2];
   wire [ticc_pkg::REG_W-1:0] wbyte = hwdata_in[7:0];
   wire wr_cfg = wr_pend_q & (addr_q == ticc_pkg::IDX_TIMER_CONFIG);
   wire wr_stat = wr_pend_q & (addr_q == ticc_pkg::IDX_EVENT_STATUS);
   wire wr_mask = wr_pend_q & (addr_q == ticc_pkg::IDX_EVENT_MASK);

   // Slave never stalls and always answers OKAY
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   // Latch the address phase; a write completes in the following cycle
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_take & hwrite_in;
         if (addr_take) begin
            addr_q <= addr_idx;
         end
      end
   end

   // Prescaler taps: code n ticks once every 2^n cycles
   wire [ticc_pkg::DIV_W-1:0] div_mask = ticc_pkg::DIV_W'((7'h01 << prescale_select_q) - 7'h01);
   wire ext_edge = ext_sync_q[1] & ~ext_sync_q[2];
   wire div_tick = ((div_q & div_mask) == div_mask);
   wire cnt_tick = (prescale_select_q == ticc_pkg::PRESCALE_EXT) ? ext_edge : div_tick;

   // Divider runs freely so every rate stays phase-locked to the bus clock
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         div_q <= 6'h00;
         ext_sync_q <= 3'h0;
      end else begin
         div_q <= div_q + 6'h01;
         ext_sync_q <= {ext_sync_q[1:0], ext_timer_clock_pin_in};
      end
   end

   // Timer configuration register
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         prescale_select_q <= ticc_pkg::PRESCALE_RESET;
      end else if (wr_cfg) begin
         prescale_select_q <= wbyte[2:0];
      end
   end

   // One counter serves every channel; it wraps at full scale
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         cnt_q <= ticc_pkg::COUNTER_RESET;
      end else if (cnt_tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Pin synchronisers; the third stage only remembers the last synced level
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
         pin_s3_q <= 6'h00;
      end else begin
         pin_s1_q <= chan_pin_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // Per-channel decode, capture qualification and register storage
   logic [ticc_pkg::NUM_CHAN-1:0] cap_evt;
   logic [ticc_pkg::NUM_CHAN-1:0] flag_irq;
   logic [ticc_pkg::REG_W-1:0] ctrl_view [ticc_pkg::NUM_CHAN];

   for (genvar ch = 0; ch < ticc_pkg::NUM_CHAN; ch++) begin : g_chan
      // Register indices of this channel
      localparam logic [ticc_pkg::IDX_W-1:0] IDX_C = ticc_pkg::IDX_W'(ticc_pkg::IDX_CHAN0_CTRL
         + ch * ticc_pkg::IDX_CHAN_STRIDE);
      localparam logic [ticc_pkg::IDX_W-1:0] IDX_H = ticc_pkg::IDX_W'(IDX_C + ticc_pkg::IDX_VALUE_HIGH_OFS);
      localparam logic [ticc_pkg::IDX_W-1:0] IDX_L = ticc_pkg::IDX_W'(IDX_C + ticc_pkg::IDX_VALUE_LOW_OFS);
      localparam bit HAS_MODE_HI = (ch % 2) == 0;

      wire wr_c = wr_pend_q & (addr_q == IDX_C);
      wire wr_h = wr_pend_q & (addr_q == IDX_H);
      wire wr_l = wr_pend_q & (addr_q == IDX_L);
      wire rise = pin_s2_q[ch] & ~pin_s3_q[ch];
      wire fall = ~pin_s2_q[ch] & pin_s3_q[ch];
      // Any mode bit set means output work, so pin edges are not captures
      wire in_capture = ~ctrl_q[ch].mode_sel_hi & ~ctrl_q[ch].mode_sel_lo;
      // Rising edge on the low select, falling on the high select, both when both set
      assign cap_evt[ch] = in_capture & ((ctrl_q[ch].edge_sel_lo & rise)
         | (ctrl_q[ch].edge_sel_hi & fall));
      assign flag_irq[ch] = ctrl_q[ch].flag & ctrl_q[ch].irq_en;
      // Odd channels read bit 5 as zero; the flop is held at zero too
      assign ctrl_view[ch] = ctrl_q[ch];

      // Control: flag set by capture wins over a clearing write
      always_ff @(posedge clk_sys_in) begin
         if (rst_in) begin
            ctrl_q[ch] <= ticc_pkg::CTRL_RESET;
         end else begin
            if (wr_c) begin
               ctrl_q[ch] <= wbyte;
               ctrl_q[ch].flag <= ctrl_q[ch].flag & wbyte[ticc_pkg::BIT_FLAG];
               ctrl_q[ch].mode_sel_hi <= HAS_MODE_HI & wbyte[ticc_pkg::BIT_MODE_HI];
            end
            if (cap_evt[ch]) begin
               ctrl_q[ch].flag <= 1'b1;
            end
         end
      end

      // Value pair has no reset; capture loads both bytes at once and beats a write
      always_ff @(posedge clk_sys_in) begin
         if (cap_evt[ch]) begin
            val_q[ch] <= cnt_q;
         end else begin
            if (wr_h) begin
               val_q[ch][15:8] <= wbyte;
            end
            if (wr_l) begin
               val_q[ch][7:0] <= wbyte;
            end
         end
      end
   end

   // Event status: set wins over write-one-to-clear
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         evt_stat_q <= ticc_pkg::EVENT_RESET;
         evt_mask_q <= ticc_pkg::EVENT_RESET;
      end else begin
         evt_stat_q <= (evt_stat_q & ~({6{wr_stat}} & wbyte[5:0])) | cap_evt;
         if (wr_mask) begin
            evt_mask_q <= wbyte[5:0];
         end
      end
   end

   // Interrupt: any enabled channel flag or any unmasked event
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= (|flag_irq) | (|(evt_stat_q & evt_mask_q));
      end
   end

   // Read mux in the data phase, from the latched index; unmapped reads zero
   always_comb begin
      hrdata_out = 32'h0000_0000;
      for (int ch = 0; ch < ticc_pkg::NUM_CHAN; ch++) begin
         if (addr_q == ticc_pkg::IDX_W'(ticc_pkg::IDX_CHAN0_CTRL + ch * ticc_pkg::IDX_CHAN_STRIDE)) begin
            hrdata_out[7:0] = ctrl_view[ch];
         end
         if (addr_q == ticc_pkg::IDX_W'(ticc_pkg::IDX_CHAN0_CTRL + ch * ticc_pkg::IDX_CHAN_STRIDE
               + ticc_pkg::IDX_VALUE_HIGH_OFS)) begin
            hrdata_out[7:0] = val_q[ch][15:8];
         end
         if (addr_q == ticc_pkg::IDX_W'(ticc_pkg::IDX_CHAN0_CTRL + ch * ticc_pkg::IDX_CHAN_STRIDE
               + ticc_pkg::IDX_VALUE_LOW_OFS)) begin
            hrdata_out[7:0] = val_q[ch][7:0];
         end
      end
      case (addr_q)
         ticc_pkg::IDX_TIMER_CONFIG: begin
            hrdata_out[2:0] = prescale_select_q;
         end
         ticc_pkg::IDX_COUNTER: begin
            hrdata_out[15:0] = cnt_q;
         end
         ticc_pkg::IDX_EVENT_STATUS: begin
            hrdata_out[5:0] = evt_stat_q;
         end
         ticc_pkg::IDX_EVENT_MASK: begin
            hrdata_out[5:0] = evt_mask_q;
         end
         default: begin
            hrdata_out[31:16] = 16'h0000;
         end
      endcase
   end

   // Checks on the channel and timer logic
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   AST_CAPTURE_LOADS: assert property (cap_evt[3] |=> val_q[3] == $past(cnt_q))
      else $error("capture did not load the counter value");
   AST_OVERWRITE_SET_FLAG: assert property ((cap_evt[3] && ctrl_q[3].flag) |=> val_q[3] == $past(cnt_q))
      else $error("capture with flag set did not overwrite");
   AST_FLAG_SETS: assert property (cap_evt[5] |=> ctrl_q[5].flag)
      else $error("capture did not set the flag");
   AST_IRQ_FROM_FLAG: assert property ((ctrl_q[3].flag && ctrl_q[3].irq_en) |=> irq_out)
      else $error("enabled flag did not raise the interrupt");
   AST_WRITE_ONE_NOP: assert property ((wr_pend_q && addr_q == ticc_pkg::IDX_CHAN3_STATUS_CONTROL
         && wbyte[7] && !ctrl_q[3].flag && !cap_evt[3]) |=> !ctrl_q[3].flag)
      else $error("writing one set the flag");
   AST_OUTPUT_IGNORES: assert property (ctrl_q[4].mode_sel_lo |-> !cap_evt[4])
      else $error("output mode channel captured");
   AST_ODD_BIT5_ZERO: assert property (!ctrl_q[5].mode_sel_hi && !ctrl_q[3].mode_sel_hi)
      else $error("odd channel bit 5 is set");
   AST_FULL_RATE: assert property ((prescale_select_q == 3'h0) [*2] |-> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("full rate counter did not step");
   // The previous code must be external too, or a divided tick taken just before the switch would count
   AST_EXT_CLOCK: assert property ((prescale_select_q == ticc_pkg::PRESCALE_EXT
         && $past(prescale_select_q) == ticc_pkg::PRESCALE_EXT && cnt_q != $past(cnt_q))
         |-> $past(ext_edge))
      else $error("external mode counted without a pin edge");
   AST_SYNC_EDGE: assert property (cap_evt[3] |-> pin_s2_q[3] != pin_s3_q[3])
      else $error("capture without a synchronised edge");

endmodule

/* verilog/ticc_pkg.sv */
// Shared constants and types of the timer input capture channel block
package ticc_pkg;

   // Channel count, counter and register widths
   localparam int unsigned NUM_CHAN = 6;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned REG_W = 8;
   localparam int unsigned IDX_W = 8;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CHAN0_CTRL = 8'h26;   // First channel control, channels follow every 3
   localparam logic [IDX_W-1:0] IDX_CHAN_STRIDE = 8'h03;  // Control, value high, value low per channel
   localparam logic [IDX_W-1:0] IDX_VALUE_HIGH_OFS = 8'h01;
   localparam logic [IDX_W-1:0] IDX_VALUE_LOW_OFS = 8'h02;
   localparam logic [IDX_W-1:0] IDX_CHAN2_VALUE_HIGH = 8'h2d;
   localparam logic [IDX_W-1:0] IDX_CHAN2_VALUE_LOW = 8'h2e;
   localparam logic [IDX_W-1:0] IDX_CHAN3_STATUS_CONTROL = 8'h2f;
   localparam logic [IDX_W-1:0] IDX_CHAN3_VALUE_HIGH = 8'h30;
   localparam logic [IDX_W-1:0] IDX_CHAN3_VALUE_LOW = 8'h31;
   localparam logic [IDX_W-1:0] IDX_CHAN4_STATUS_CONTROL = 8'h32;
   localparam logic [IDX_W-1:0] IDX_CHAN4_VALUE_HIGH = 8'h33;
   localparam logic [IDX_W-1:0] IDX_CHAN4_VALUE_LOW = 8'h34;
   localparam logic [IDX_W-1:0] IDX_CHAN5_STATUS_CONTROL = 8'h35;
   localparam logic [IDX_W-1:0] IDX_CHAN5_VALUE_HIGH = 8'h36;
   localparam logic [IDX_W-1:0] IDX_CHAN5_VALUE_LOW = 8'h37;
   localparam logic [IDX_W-1:0] IDX_TIMER_CONFIG = 8'h40;  // Prescale select in bits 2..0
   localparam logic [IDX_W-1:0] IDX_COUNTER = 8'h41;       // Counter value, read only
   localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 8'h42;  // Sticky capture events, write one to clear
   localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 8'h43;    // Event interrupt mask

   // Control register field positions
   localparam int unsigned BIT_FLAG = 7;
   localparam int unsigned BIT_IRQ_EN = 6;
   localparam int unsigned BIT_MODE_HI = 5;

   // Reset values
   localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   localparam logic [CNT_W-1:0] COUNTER_RESET = 16'h0000;
   localparam logic [NUM_CHAN-1:0] EVENT_RESET = 6'h00;

   // Prescaler: seven divided rates, the eighth code takes the external clock
   localparam int unsigned DIV_W = 6;
   localparam logic [2:0] PRESCALE_EXT = 3'h7;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Channel status and control register layout
   typedef struct packed {
      logic flag;         // Capture event flag
      logic irq_en;       // Channel interrupt enable
      logic mode_sel_hi;  // Mode select high (even channels only)
      logic mode_sel_lo;  // Mode select low
      logic edge_sel_hi;  // Falling edge select
      logic edge_sel_lo;  // Rising edge select
      logic toggle_on_wrap;
      logic full_duty;
   } ticc_chan_ctrl_t;

endpackage
